// ### design/mic_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// R1 - Second register bits 3..0 enable four sources
// R2 - Bits 6,4 set clock/serial-bus priority level
// R3 - Equal level resolved by fixed polling order
// R4 - Supply monitor alone on highest third level
// R5 - Each source has its fixed vector address
// R6 - Take pushes PC, loads vector; return pops
// R7 - Handler software saves its own working registers
// R8 - One instruction after return or register access
// R9 - Latency between 3.25 and 16.25 instruction cycles
// R10 - Wake-up from core-off makes external request pending
// R11 - External flags frozen while core is off
// R12 - Clock, temperature, serial-bus requests latched until entry
// R13 - Multi-source vectors never auto-cleared on entry
// R14 - External auto-clear only in falling-edge mode
// R15 - Request flags come from peripheral control registers
// R16 - Status flags kept by clock, watchdog, serial bus
// R17 - High preempts low; same level never nests
// R18 - Global enable bit gates every source
module mic_ctrl
  import mic_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Special register port from the core
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  // Request flags kept by peripherals, level
  input  wire logic        i_timer0_overflow_flag,
  input  wire logic        i_timer1_overflow_flag,
  input  wire logic        i_transmit_done,
  input  wire logic        i_receive_done,
  input  wire logic        i_timer2_overflow_flag,
  input  wire logic        i_timer2_external_flag,
  input  wire logic        i_supply_event_flag,
  input  wire logic        i_metering_request_flag,
  input  wire logic        i_watchdog_timeout_flag,
  // Event pulses for latched sources
  input  wire logic        i_clock_interval_source,
  input  wire logic        i_temperature_source,
  input  wire logic        i_serial_bus_source,
  // External pins, active low, asynchronous
  input  wire logic        i_ext0_pin_n,
  input  wire logic        i_ext1_pin_n,
  input  wire logic        i_ext0_edge_select,
  input  wire logic        i_ext1_edge_select,
  // Core handshake
  input  wire logic        i_core_off_mode,
  input  wire logic        i_wake_ext0,
  input  wire logic        i_wake_ext1,
  input  wire logic        i_insn_done,
  input  wire logic        i_return_from_handler,
  input  wire logic        i_vector_taken,
  // Outputs to the core
  output logic             o_int_req,
  output logic      [15:0] o_vector,
  output logic             o_push_pc,
  output logic             o_pop_pc,
  output logic             o_ext0_request_flag,
  output logic             o_ext1_request_flag
);
  logic [7:0]      primary_enable_r;
  logic [7:0]      primary_prio_r;
  logic [7:0]      enable_priority_two_reg_r;
  logic [1:0]      ext0_sync_r;
  logic [1:0]      ext1_sync_r;
  logic            ext0_prev_r;
  logic            ext1_prev_r;
  logic            ext0_request_flag_r;
  logic            ext1_request_flag_r;
  logic [2:0]      latched_r;   // clock, temperature, serial bus
  logic [2:0]      active_r;    // in service per level
  logic            block_r;
  logic [7:0]      lat_cnt_r;
  logic [3:0]      win_idx_r;
  logic [1:0]      win_lvl_r;
  mic_state_e      state_r;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] ena;
  logic [NSRC-1:0] prio_high;
  logic [NSRC-1:0] cand_psm;
  logic [NSRC-1:0] cand_high;
  logic [NSRC-1:0] cand_low;
  logic            any_psm;
  logic            any_high;
  logic            any_low;
  logic [3:0]      idx_psm;
  logic [3:0]      idx_high;
  logic [3:0]      idx_low;
  logic            pick;
  logic [3:0]      pick_idx;
  logic [1:0]      pick_lvl;
  logic            reg_access;
  logic            ext0_level;
  logic            ext1_level;

  // Two-flop synchronisers; the pins are active low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext0_sync_r <= 2'h3;
      ext1_sync_r <= 2'h3;
      ext0_prev_r <= 1'b1;
      ext1_prev_r <= 1'b1;
    end else begin
      ext0_sync_r <= {ext0_sync_r[0], i_ext0_pin_n};
      ext1_sync_r <= {ext1_sync_r[0], i_ext1_pin_n};
      ext0_prev_r <= ext0_sync_r[1];
      ext1_prev_r <= ext1_sync_r[1];
    end
  end
  assign ext0_level = ~ext0_sync_r[1];
  assign ext1_level = ~ext1_sync_r[1];
  assign reg_access = (i_sfr_wr | i_sfr_rd) &&
                      (i_sfr_addr == ADDR_PRIMARY_ENABLE ||
                       i_sfr_addr == ADDR_PRIMARY_PRIO ||
                       i_sfr_addr == ADDR_ENABLE_PRIO_TWO);

  // Register writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      primary_enable_r          <= RST_PRIMARY_ENABLE;
      primary_prio_r            <= RST_PRIMARY_PRIO;
      enable_priority_two_reg_r <= RST_ENABLE_PRIO_TWO;
    end else if (i_sfr_wr) begin
      if (i_sfr_addr == ADDR_PRIMARY_ENABLE) begin
        primary_enable_r <= i_sfr_wdata;
      end else if (i_sfr_addr == ADDR_PRIMARY_PRIO) begin
        primary_prio_r <= i_sfr_wdata;
      end else if (i_sfr_addr == ADDR_ENABLE_PRIO_TWO) begin
        // Reserved bits 7 and 5 hold their reset ones
        enable_priority_two_reg_r <= (i_sfr_wdata & MASK_ENABLE_PRIO_TWO)
                                   | (RST_ENABLE_PRIO_TWO
                                      & ~MASK_ENABLE_PRIO_TWO); // R2
      end
    end
  end

  // Register reads, registered one cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      if (i_sfr_addr == ADDR_PRIMARY_ENABLE) begin
        o_sfr_rdata <= primary_enable_r;
      end else if (i_sfr_addr == ADDR_PRIMARY_PRIO) begin
        o_sfr_rdata <= primary_prio_r;
      end else if (i_sfr_addr == ADDR_ENABLE_PRIO_TWO) begin
        o_sfr_rdata <= enable_priority_two_reg_r;
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

  // External flags: set wins over clear; frozen while core is off
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext0_request_flag_r <= 1'b0;
      ext1_request_flag_r <= 1'b0;
    end else if (!i_core_off_mode) begin  // R11
      if (i_ext0_edge_select) begin
        if (ext0_prev_r && !ext0_sync_r[1]) begin
          ext0_request_flag_r <= 1'b1;
        end else if (i_vector_taken && state_r == MIC_ACK &&
                     win_idx_r == SRC_EXT0) begin
          ext0_request_flag_r <= 1'b0;  // R14
        end
      end else begin
        ext0_request_flag_r <= ext0_level;  // R14
      end
      if (i_ext1_edge_select) begin
        if (ext1_prev_r && !ext1_sync_r[1]) begin
          ext1_request_flag_r <= 1'b1;
        end else if (i_vector_taken && state_r == MIC_ACK &&
                     win_idx_r == SRC_EXT1) begin
          ext1_request_flag_r <= 1'b0;  // R14
        end
      end else begin
        ext1_request_flag_r <= ext1_level;
      end
    end
  end

  // Latched sources cleared only on their handler entry, set wins
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      latched_r <= 3'h0;
    end else begin
      latched_r <= (latched_r & ~({3{i_vector_taken && state_r == MIC_ACK}}
                   & {win_idx_r == SRC_SBUS, win_idx_r == SRC_TEMP,
                      win_idx_r == SRC_RTC}))
                 | {i_serial_bus_source, i_temperature_source,
                    i_clock_interval_source};  // R12
    end
  end

  // Requests in polling order; wake-ups count as pending externals
  assign req[SRC_PSM]  = i_supply_event_flag;  // R15
  assign req[SRC_RTC]  = latched_r[0];
  assign req[SRC_MTR]  = i_metering_request_flag;
  assign req[SRC_WDT]  = i_watchdog_timeout_flag;  // R16
  assign req[SRC_TEMP] = latched_r[1];
  assign req[SRC_EXT0] = ext0_request_flag_r | i_wake_ext0;  // R10
  assign req[SRC_TMR0] = i_timer0_overflow_flag;
  assign req[SRC_EXT1] = ext1_request_flag_r | i_wake_ext1;  // R10
  assign req[SRC_TMR1] = i_timer1_overflow_flag;
  assign req[SRC_SBUS] = latched_r[2];
  assign req[SRC_UART] = i_transmit_done | i_receive_done;
  assign req[SRC_TMR2] = i_timer2_overflow_flag | i_timer2_external_flag;

  assign ena[SRC_PSM]  = enable_priority_two_reg_r[B2_SUPPLY_EN];  // R1
  assign ena[SRC_RTC]  = enable_priority_two_reg_r[B2_INTERVAL_EN];
  assign ena[SRC_MTR]  = enable_priority_two_reg_r[B2_METERING_EN];
  assign ena[SRC_WDT]  = 1'b1;
  assign ena[SRC_TEMP] = primary_enable_r[B1_TEMP];
  assign ena[SRC_EXT0] = primary_enable_r[B1_EXT0];
  assign ena[SRC_TMR0] = primary_enable_r[B1_TMR0];
  assign ena[SRC_EXT1] = primary_enable_r[B1_EXT1];
  assign ena[SRC_TMR1] = primary_enable_r[B1_TMR1];
  assign ena[SRC_SBUS] = enable_priority_two_reg_r[B2_SERIAL_BUS_EN];
  assign ena[SRC_UART] = primary_enable_r[B1_UART];
  assign ena[SRC_TMR2] = primary_enable_r[B1_TMR2];

  assign prio_high = {primary_prio_r[B1_TMR2], primary_prio_r[B1_UART],
                      enable_priority_two_reg_r[B2_SERIAL_BUS_PRIO],
                      primary_prio_r[B1_TMR1], primary_prio_r[B1_EXT1],
                      primary_prio_r[B1_TMR0], primary_prio_r[B1_EXT0],
                      primary_prio_r[B1_TEMP], 1'b0,
                      primary_prio_r[BP_METERING],
                      enable_priority_two_reg_r[B2_CLOCK_ALARM_PRIO],
                      1'b0};  // R2

  always_comb begin
    cand_psm  = '0;
    cand_high = '0;
    cand_low  = '0;
    if (primary_enable_r[B1_GLOBAL_EN]) begin  // R18
      cand_psm[SRC_PSM] = req[SRC_PSM] & ena[SRC_PSM];  // R4
      cand_high = req & ena & prio_high;
      cand_low  = req & ena & ~prio_high;
      cand_high[SRC_PSM] = 1'b0;
      cand_low[SRC_PSM]  = 1'b0;
    end
  end

  mic_poll u_poll_psm (.i_req(cand_psm),  .o_any(any_psm),
                       .o_idx(idx_psm));
  mic_poll u_poll_hi  (.i_req(cand_high), .o_any(any_high),
                       .o_idx(idx_high));
  mic_poll u_poll_lo  (.i_req(cand_low),  .o_any(any_low),
                       .o_idx(idx_low));

  // Nesting only into a level above every level in service
  always_comb begin
    pick     = 1'b0;
    pick_idx = idx_low;
    pick_lvl = LVL_LOW;
    if (any_psm && !active_r[LVL_PSM]) begin  // R4
      pick = 1'b1;
      pick_idx = idx_psm;
      pick_lvl = LVL_PSM;
    end else if (any_high && active_r[LVL_PSM:LVL_HIGH] == 2'h0) begin
      pick = 1'b1;  // R17
      pick_idx = idx_high;
      pick_lvl = LVL_HIGH;
    end else if (any_low && active_r == 3'h0) begin
      pick = 1'b1;
      pick_idx = idx_low;
      pick_lvl = LVL_LOW;
    end
  end

  // Block vectoring until one more instruction completes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      block_r <= 1'b0;
    end else if (i_return_from_handler || reg_access) begin
      block_r <= 1'b1;  // R8
    end else if (i_insn_done) begin
      block_r <= 1'b0;
    end
  end

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    logic [15:0] v;
    v = VEC_WDT;
    case (idx)
      SRC_PSM:  v = VEC_PSM;
      SRC_RTC:  v = VEC_RTC;
      SRC_MTR:  v = VEC_MTR;
      SRC_TEMP: v = VEC_TEMP;
      SRC_EXT0: v = VEC_EXT0;
      SRC_TMR0: v = VEC_TMR0;
      SRC_EXT1: v = VEC_EXT1;
      SRC_TMR1: v = VEC_TMR1;
      SRC_SBUS: v = VEC_SBUS;
      SRC_UART: v = VEC_UART;
      SRC_TMR2: v = VEC_TMR2;
      default:  v = VEC_WDT;
    endcase
    return v;  // R5
  endfunction

  // Take sequence: wait the minimum latency, then request the vector
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r   <= MIC_IDLE;
      lat_cnt_r <= 8'h00;
      win_idx_r <= 4'h0;
      win_lvl_r <= LVL_LOW;
      o_int_req <= 1'b0;
      o_vector  <= 16'h0000;
    end else begin
      case (state_r)
        MIC_IDLE: begin
          if (pick && !block_r && !i_core_off_mode) begin
            state_r   <= MIC_WAIT;
            lat_cnt_r <= 8'h01;
            win_idx_r <= pick_idx;
            win_lvl_r <= pick_lvl;
          end
        end
        MIC_WAIT: begin
          // Re-poll every cycle: a later higher request still wins, and
          // a request withdrawn or globally disabled is never taken
          if (!pick) begin
            state_r <= MIC_IDLE;  // R18
          end else begin
            win_idx_r <= pick_idx;
            win_lvl_r <= pick_lvl;
            lat_cnt_r <= lat_cnt_r + 8'h01;
            if (lat_cnt_r >= LAT_MIN_CYC - 8'h01 && !block_r) begin  // R9
              state_r   <= MIC_ACK;
              o_int_req <= 1'b1;
              o_vector  <= vec_of(pick_idx);
            end
          end
        end
        MIC_ACK: begin
          if (i_vector_taken) begin
            state_r   <= MIC_IDLE;
            o_int_req <= 1'b0;
          end
        end
        default: state_r <= MIC_IDLE;
      endcase
    end
  end

  // In-service levels: set on entry, highest cleared on return
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      active_r <= 3'h0;
    end else if (state_r == MIC_ACK && i_vector_taken) begin
      active_r[win_lvl_r] <= 1'b1;  // R17
    end else if (i_return_from_handler) begin
      if (active_r[LVL_PSM]) begin
        active_r[LVL_PSM] <= 1'b0;
      end else if (active_r[LVL_HIGH]) begin
        active_r[LVL_HIGH] <= 1'b0;
      end else begin
        active_r[LVL_LOW] <= 1'b0;
      end
    end
  end

  // Stack strobes; flags of multi-source vectors left to software
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_push_pc <= 1'b0;
      o_pop_pc  <= 1'b0;
    end else begin
      o_push_pc <= state_r == MIC_ACK && i_vector_taken;  // R6 R13
      o_pop_pc  <= i_return_from_handler;  // R6
    end
  end

  assign o_ext0_request_flag = ext0_request_flag_r;
  assign o_ext1_request_flag = ext1_request_flag_r;

  AST_LATENCY_MIN: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_int_req) |-> $past(state_r, 1) == MIC_WAIT
                         && $past(lat_cnt_r) >= LAT_MIN_CYC - 8'h01) // R9
    else $error("vector requested before minimum latency");
  AST_NO_GLOBAL: assert property (@(posedge i_clk) disable iff (i_rst)
    !primary_enable_r[B1_GLOBAL_EN] |-> !pick)  // R18
    else $error("pick while globally disabled");
  AST_BLOCK: assert property (@(posedge i_clk) disable iff (i_rst)
    i_return_from_handler |=> !$rose(o_int_req))  // R8
    else $error("vector right after return");
  AST_PSM_VEC: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_int_req) && win_lvl_r == LVL_PSM |-> o_vector == VEC_PSM) // R4
    else $error("top level not supply monitor");
  AST_SAME_LVL: assert property (@(posedge i_clk) disable iff (i_rst)
    active_r[LVL_HIGH] && !active_r[LVL_PSM] && pick
      |-> pick_lvl == LVL_PSM)  // R17
    else $error("same level nested");
  sequence s_entry;
    state_r == MIC_ACK && i_vector_taken;
  endsequence
  AST_PUSH: assert property (@(posedge i_clk) disable iff (i_rst)
    s_entry |=> o_push_pc && !o_int_req)  // R6
    else $error("no push on entry");
  AST_OFF_FREEZE: assert property (@(posedge i_clk) disable iff (i_rst)
    i_core_off_mode |=> $stable(ext0_request_flag_r))  // R11
    else $error("ext flag changed while off");
  AST_LATCH: assert property (@(posedge i_clk) disable iff (i_rst)
    i_temperature_source |=> latched_r[1])  // R12
    else $error("temperature request lost");
endmodule

// ### design/mic_poll.sv
`timescale 1ns/1ps
// Fixed-order poll: lowest set index wins
module mic_poll
  import mic_pkg::*;
(
  // Candidate requests
  input  wire logic [NSRC-1:0] i_req,
  // Winner
  output logic                 o_any,
  output logic [3:0]           o_idx
);
  always_comb begin
    o_any = 1'b0;
    o_idx = 4'h0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (i_req[k]) begin
        o_any = 1'b1;
        o_idx = 4'(k);  // R3
      end
    end
  end
endmodule

// ### inc/mic_pkg.sv
package mic_pkg;
  // Source indices follow the polling order, index 0 polled first
  localparam int NSRC = 12;
  localparam logic [3:0] SRC_PSM   = 4'h0;
  localparam logic [3:0] SRC_RTC   = 4'h1;
  localparam logic [3:0] SRC_MTR   = 4'h2;
  localparam logic [3:0] SRC_WDT   = 4'h3;
  localparam logic [3:0] SRC_TEMP  = 4'h4;
  localparam logic [3:0] SRC_EXT0  = 4'h5;
  localparam logic [3:0] SRC_TMR0  = 4'h6;
  localparam logic [3:0] SRC_EXT1  = 4'h7;
  localparam logic [3:0] SRC_TMR1  = 4'h8;
  localparam logic [3:0] SRC_SBUS  = 4'h9;
  localparam logic [3:0] SRC_UART  = 4'hA;
  localparam logic [3:0] SRC_TMR2  = 4'hB;

  // Register addresses on the core's special register port
  localparam logic [7:0] ADDR_PRIMARY_ENABLE  = 8'hA8;
  localparam logic [7:0] ADDR_PRIMARY_PRIO    = 8'hB8;
  localparam logic [7:0] ADDR_ENABLE_PRIO_TWO = 8'hA9;
  localparam logic [7:0] RST_PRIMARY_ENABLE   = 8'h00;
  localparam logic [7:0] RST_PRIMARY_PRIO     = 8'h00;
  localparam logic [7:0] RST_ENABLE_PRIO_TWO  = 8'hA0;
  localparam logic [7:0] MASK_ENABLE_PRIO_TWO = 8'h5F;

  // Field positions, second enable/priority register
  localparam int B2_CLOCK_ALARM_PRIO = 6;
  localparam int B2_SERIAL_BUS_PRIO  = 4;
  localparam int B2_METERING_EN      = 3;
  localparam int B2_INTERVAL_EN      = 2;
  localparam int B2_SUPPLY_EN        = 1;
  localparam int B2_SERIAL_BUS_EN    = 0;
  // Field positions, primary enable and priority registers
  localparam int B1_GLOBAL_EN = 7;
  localparam int B1_TEMP      = 6;
  localparam int B1_TMR2      = 5;
  localparam int B1_UART      = 4;
  localparam int B1_TMR1      = 3;
  localparam int B1_EXT1      = 2;
  localparam int B1_TMR0      = 1;
  localparam int B1_EXT0      = 0;
  localparam int BP_METERING  = 7;

  // Vector table
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TMR0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001B;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_TMR2 = 16'h002B;
  localparam logic [15:0] VEC_TEMP = 16'h0033;
  localparam logic [15:0] VEC_SBUS = 16'h003B;
  localparam logic [15:0] VEC_PSM  = 16'h0043;
  localparam logic [15:0] VEC_MTR  = 16'h004B;
  localparam logic [15:0] VEC_RTC  = 16'h0053;
  localparam logic [15:0] VEC_WDT  = 16'h005B;

  // Latency in quarter instruction cycles; core clock cycles per quarter
  localparam int LAT_MIN_QTR = 13;  // 3.25 instruction cycles
  localparam int LAT_MAX_QTR = 65;  // 16.25 instruction cycles
  localparam int CLK_PER_QTR = 1;
  localparam logic [7:0] LAT_MIN_CYC = 8'(LAT_MIN_QTR * CLK_PER_QTR);
  localparam logic [7:0] LAT_MAX_CYC = 8'(LAT_MAX_QTR * CLK_PER_QTR);

  // Priority levels
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_PSM  = 2'h2;

  typedef enum logic [2:0] {
    MIC_IDLE = 3'b001,
    MIC_WAIT = 3'b010,
    MIC_ACK  = 3'b100
  } mic_state_e;
endpackage

// ### tb/mic_core_model.sv
`timescale 1ns/1ps
// Core side: takes vectors after a delay and returns when told to
module mic_core_model #(
  parameter int ACK_DLY = 2
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // From the controller
  input  wire logic        i_int_req,
  input  wire logic [15:0] i_vector,
  input  wire logic        i_push_pc,
  input  wire logic        i_pop_pc,
  input  wire logic        i_ret_cmd,
  // To the controller
  output logic             o_insn_done,
  output logic             o_vector_taken,
  output logic             o_return_from_handler,
  // Bookkeeping for the bench
  output logic      [15:0] o_last_vec,
  output int               o_takes,
  output int               o_pushes,
  output int               o_pops
);
  logic [1:0] ins_cnt_r;
  int         wait_r;

  // Four quarters make one instruction
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ins_cnt_r <= 2'h0;
      o_insn_done <= 1'b0;
    end else begin
      ins_cnt_r <= ins_cnt_r + 2'h1;
      o_insn_done <= (ins_cnt_r == 2'h3);
    end
  end

  // Ack is dropped at the edge that sees it, so one request is one take
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_r <= 0;
      o_vector_taken <= 1'b0;
      o_last_vec <= 16'h0000;
      o_takes <= 0;
    end else if (!i_int_req) begin
      wait_r <= 0;
      o_vector_taken <= 1'b0;
    end else if (o_vector_taken) begin
      wait_r <= 0;
      o_vector_taken <= 1'b0;
      o_last_vec <= i_vector;
      o_takes <= o_takes + 1;
    end else if (wait_r == ACK_DLY) begin
      o_vector_taken <= 1'b1;
    end else begin
      wait_r <= wait_r + 1;
    end
  end

  // Return is issued one cycle after the command; stack strobes are counted
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_return_from_handler <= 1'b0;
      o_pushes <= 0;
      o_pops <= 0;
    end else begin
      o_return_from_handler <= i_ret_cmd;
      o_pushes <= o_pushes + int'(i_push_pc);
      o_pops <= o_pops + int'(i_pop_pc);
    end
  end
endmodule

// ### tb/mic_ctrl_test.sv
`timescale 1ns/1ps
module mic_ctrl_test
  import mic_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        ret_cmd = 1'b0, edge_r = 1'b1;
  logic        off_r = 1'b0, wake_r = 1'b0, f0, f1;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [11:0] lvl = 12'h000;
  logic        int_req, push, pop, ins, taken, rfh;
  logic [15:0] vec, last_vec;
  int          takes, pushes, pops, rets = 0, lat = 0;
  int          errors = 0, n_checks = 0;
  logic [15:0] vt [12] = '{VEC_PSM, VEC_RTC, VEC_MTR, VEC_WDT, VEC_TEMP,
    VEC_EXT0, VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_SBUS, VEC_UART, VEC_TMR2};

  always #50 clk = ~clk;

  mic_ctrl dut_u (
    .i_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_timer0_overflow_flag(lvl[6]), .i_timer1_overflow_flag(lvl[8]),
    .i_transmit_done(lvl[10]), .i_receive_done(lvl[10]),
    .i_timer2_overflow_flag(lvl[11]), .i_timer2_external_flag(lvl[11]),
    .i_supply_event_flag(lvl[0]), .i_metering_request_flag(lvl[2]),
    .i_watchdog_timeout_flag(lvl[3]), .i_clock_interval_source(lvl[1]),
    .i_temperature_source(lvl[4]), .i_serial_bus_source(lvl[9]),
    .i_ext0_pin_n(~lvl[5]), .i_ext1_pin_n(~lvl[7]),
    .i_ext0_edge_select(edge_r), .i_ext1_edge_select(edge_r),
    .i_core_off_mode(off_r), .i_wake_ext0(wake_r), .i_wake_ext1(1'b0),
    .i_insn_done(ins), .i_return_from_handler(rfh),
    .i_vector_taken(taken), .o_int_req(int_req), .o_vector(vec),
    .o_push_pc(push), .o_pop_pc(pop), .o_ext0_request_flag(f0),
    .o_ext1_request_flag(f1));

  mic_core_model #(.ACK_DLY(2)) core_u (
    .i_clk(clk), .i_rst(rst), .i_int_req(int_req), .i_vector(vec),
    .i_push_pc(push), .i_pop_pc(pop), .i_ret_cmd(ret_cmd),
    .o_insn_done(ins), .o_vector_taken(taken),
    .o_return_from_handler(rfh), .o_last_vec(last_vec),
    .o_takes(takes), .o_pushes(pushes), .o_pops(pops));

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask

  // Event sources are one-cycle pulses, the rest stay until dropped
  task automatic raise(input logic [11:0] m);
    @(posedge clk);
    lvl <= lvl | m;
    @(posedge clk);
    lvl <= lvl & ~12'h212;
  endtask

  task automatic drop(input logic [11:0] m);
    @(posedge clk);
    lvl <= lvl & ~m;
  endtask

  task automatic ret();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    rets++;
  endtask

  task automatic take(input logic [15:0] exp);
    int n0;
    int k;
    n0 = takes;
    k = 0;
    while (takes == n0 && k < 200) begin
      @(negedge clk);
      if (!int_req) lat = k;
      k++;
    end
    chk(16'(takes - n0), 16'h0001);
    chk(last_vec, exp);
  endtask

  task automatic none(input int n);
    int n0;
    n0 = takes;
    repeat (n) @(negedge clk);
    chk(16'(takes - n0), 16'h0000);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    sfr_rd(ADDR_PRIMARY_ENABLE, 8'h00);
    sfr_rd(ADDR_PRIMARY_PRIO, 8'h00);
    sfr_rd(ADDR_ENABLE_PRIO_TWO, 8'hA0);
    sfr_rd(8'h55, 8'h00);
    sfr_wr(ADDR_ENABLE_PRIO_TWO, 8'h00);
    sfr_rd(ADDR_ENABLE_PRIO_TWO, 8'hA0);
    sfr_wr(ADDR_ENABLE_PRIO_TWO, 8'h5F);
    sfr_rd(ADDR_ENABLE_PRIO_TWO, 8'hFF);
    sfr_wr(ADDR_PRIMARY_ENABLE, 8'h7F);
    raise(12'h040);
    none(40);
    sfr_wr(ADDR_PRIMARY_ENABLE, 8'hFF);
    take(VEC_TMR0);
    drop(12'h040);
    ret();
    sfr_wr(ADDR_ENABLE_PRIO_TWO, 8'h57);
    raise(12'h004);
    none(40);
    sfr_wr(ADDR_ENABLE_PRIO_TWO, 8'h5F);
    take(VEC_MTR);
    drop(12'h004);
    ret();
    sfr_wr(ADDR_ENABLE_PRIO_TWO, 8'h0F);
    sfr_rd(ADDR_ENABLE_PRIO_TWO, 8'hAF);
    raise(12'hFFF);
    for (int i = 0; i < 12; i++) begin
      take(vt[i]);
      if (i == 0) chk(16'(lat >= 10 && lat <= 65), 16'h0001);
      drop(12'(1 << i));
      ret();
    end
    sfr_wr(ADDR_ENABLE_PRIO_TWO, 8'h7F);
    raise(12'h040);
    take(VEC_TMR0);
    drop(12'h040);
    raise(12'h100);
    none(40);
    raise(12'h002);
    take(VEC_RTC);
    raise(12'h001);
    take(VEC_PSM);
    ret();
    take(VEC_PSM);
    drop(12'h001);
    ret();
    ret();
    ret();
    take(VEC_TMR1);
    drop(12'h100);
    ret();
    @(posedge clk);
    edge_r <= 1'b0;
    raise(12'h020);
    take(VEC_EXT0);
    chk({15'h0000, f0}, 16'h0001);
    ret();
    take(VEC_EXT0);
    drop(12'h020);
    ret();
    none(40);
    @(posedge clk);
    off_r <= 1'b1;
    raise(12'h0A0);
    none(10);
    chk({14'h0000, f1, f0}, 16'h0000);
    drop(12'h0A0);
    none(10);
    @(posedge clk);
    off_r <= 1'b0;
    wake_r <= 1'b1;
    take(VEC_EXT0);
    @(posedge clk);
    wake_r <= 1'b0;
    ret();
    none(40);
    chk(16'(pushes), 16'(takes));
    chk(16'(pops), 16'(rets));
    stop_test();
  end
endmodule
